/* hdl/ife_irq_ctrl.v */
// Purpose: interrupt flags, enables, vector sequencing and bit operations
// Assumes: CPU core drives page-zero strobes on clk, one cycle each
// Notes:   ports A/B are open drain; a zero in the data register pulls low
`timescale 1ns/1ps
`include "ife_consts.vh"
module ife_irq_ctrl (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Page-zero access from the CPU core
  input  wire [7:0] zp_addr,
  input  wire       zp_rd,
  input  wire       zp_wr,
  input  wire       zp_rmw,
  input  wire [7:0] zp_wdata,
  output reg  [7:0] zp_rdata,
  output reg        zp_hit,
  // Bit instruction helper
  input  wire       bop_valid,
  input  wire [7:0] bop_opcode,
  input  wire [7:0] bop_operand,
  output reg        bop_done,
  output reg  [7:0] bop_result,
  output reg        bop_is_branch,
  output reg        bop_taken,
  output reg        bop_bad,
  // Interrupt sequencing
  input  wire       nmi_n_pin,
  input  wire       cpu_irq_mask,
  input  wire       vec_ack,
  output reg        vec_valid,
  output reg  [1:0] vec_kind,
  output reg [15:0] vec_addr,
  output reg        irq_req,
  // Event sources
  input  wire       ctr_a_underflow,
  input  wire       ctr_b_underflow,
  input  wire [7:0] serial_status,
  // Port A pins
  input  wire [7:0] port_a_in,
  output reg  [7:0] port_a_out,
  output reg  [7:0] port_a_oe,
  // Port B pins
  input  wire [7:0] port_b_in,
  output reg  [7:0] port_b_out,
  output reg  [7:0] port_b_oe
);

  localparam ST_IDLE = 1'b0;
  localparam ST_VEC  = 1'b1;

  reg        rst_meta;
  reg        rst_sync;
  reg  [7:0] irq_flags;
  reg  [7:0] irq_enables;
  reg  [7:0] port_a_data;
  reg  [7:0] port_b_data;
  reg        state;
  reg        reset_pend;
  reg        nmi_pend;

  reg  [7:0] next_flags;
  reg  [7:0] next_enables;
  reg  [7:0] next_rdata;
  reg        next_hit;
  reg  [3:0] edge_keep;
  reg        ctra_clr;
  reg        ctrb_clr;

  wire [7:0] pa_level;
  wire [7:0] pa_rise;
  wire [7:0] pa_fall;
  wire [7:0] pb_level;
  wire [0:0] nmi_fall;

  wire       rd_hit_any;
  wire       wr_flag_clr;
  wire [2:0] bop_bit;
  wire [7:0] bop_mask;
  wire [3:0] bop_low;
  wire       bop_bit_val;

  // Reset release through two flops
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Pin synchronisers and edge detection
  ife_sync_edge #(.WIDTH(8)) u_sync_pa (
    .clk    (clk),
    .rst_n  (rst_sync),
    .pin_in (port_a_in),
    .level  (pa_level),
    .rise   (pa_rise),
    .fall   (pa_fall)
  );

  ife_sync_edge #(.WIDTH(8)) u_sync_pb (
    .clk    (clk),
    .rst_n  (rst_sync),
    .pin_in (port_b_in),
    .level  (pb_level),
    .rise   (),
    .fall   ()
  );

  ife_sync_edge #(.WIDTH(1)) u_sync_nmi (
    .clk    (clk),
    .rst_n  (rst_sync),
    .pin_in (nmi_n_pin),
    .level  (),
    .rise   (),
    .fall   (nmi_fall)
  );

  assign wr_flag_clr = zp_wr && (zp_addr == `IFE_ADDR_FLAG_CLR);
  assign rd_hit_any  = (zp_addr == `IFE_ADDR_PORT_A) ||
                       (zp_addr == `IFE_ADDR_PORT_B) ||
                       (zp_addr == `IFE_ADDR_FLAG_CLR) ||
                       (zp_addr == `IFE_ADDR_FLAGS) ||
                       (zp_addr == `IFE_ADDR_ENABLES);

  // Flag register next value
  always @*
  begin
    // Clear-bit at the clear alias writes only zero bits that hit
    edge_keep = 4'hF;
    if (wr_flag_clr)
      edge_keep = zp_wdata[3:0];
    ctra_clr = (zp_rd && (zp_addr == `IFE_ADDR_CTRA_LO)) ||
               (zp_wr && (zp_addr == `IFE_ADDR_CTRA_WR));
    ctrb_clr = (zp_rd && (zp_addr == `IFE_ADDR_CTRB_LO)) ||
               (zp_wr && (zp_addr == `IFE_ADDR_CTRB_WR));
    next_flags = irq_flags;
    // Ones written are ANDed, so they cannot set; new edges win a clear
    next_flags[3:0] = (irq_flags[3:0] & edge_keep) |
                      {pa_fall[3:2], pa_rise[1:0]};
    next_flags[`IFE_FLAG_CTRA] = ctr_a_underflow |
                     (irq_flags[`IFE_FLAG_CTRA] & ~ctra_clr);
    next_flags[`IFE_FLAG_CTRB] = ctr_b_underflow |
                     (irq_flags[`IFE_FLAG_CTRB] & ~ctrb_clr);
    // Serial flags follow the status bits as levels
    next_flags[`IFE_FLAG_RX] = |serial_status[3:0];
    next_flags[`IFE_FLAG_TX] =
      (serial_status[`IFE_SS_TX_EMPTY] & ~serial_status[`IFE_SS_TX_IDLE]) |
      serial_status[`IFE_SS_TX_END];
  end

  // Enable register next value
  always @*
  begin
    next_enables = irq_enables;
    if (zp_wr && (zp_addr == `IFE_ADDR_ENABLES))
      next_enables = zp_wdata;
  end

  // Read data mux
  always @*
  begin
    next_rdata = zp_rdata;
    next_hit   = 1'b0;
    if (zp_rd)
    begin
      next_hit = rd_hit_any;
      case (zp_addr)
        `IFE_ADDR_PORT_A:
          // Read cycle of a bit instruction sees the latch, not the pins
          next_rdata = zp_rmw ? port_a_data : pa_level;
        `IFE_ADDR_PORT_B:
          next_rdata = zp_rmw ? port_b_data : pb_level;
        `IFE_ADDR_FLAG_CLR:
          next_rdata = `IFE_CLR_READ_VAL;
        `IFE_ADDR_FLAGS:
          next_rdata = irq_flags;
        `IFE_ADDR_ENABLES:
          next_rdata = irq_enables;
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  // Registers, read data and request
  always @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      irq_flags   <= `IFE_FLAGS_RESET;
      irq_enables <= `IFE_ENABLES_RESET;
      zp_rdata    <= 8'h00;
      zp_hit      <= 1'b0;
      irq_req     <= 1'b0;
    end
    else
    begin
      irq_flags   <= next_flags;
      irq_enables <= next_enables;
      zp_rdata    <= next_rdata;
      zp_hit      <= next_hit;
      // Level request held while any enabled flag remains
      irq_req <= |(next_flags & next_enables);
    end
  end

  // Port data registers; a zero bit drives the pin low
  always @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      port_a_data <= `IFE_PORT_RESET;
      port_b_data <= `IFE_PORT_RESET;
      port_a_oe   <= 8'h00;
      port_b_oe   <= 8'h00;
      port_a_out  <= 8'h00;
      port_b_out  <= 8'h00;
    end
    else
    begin
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
      if (zp_wr && (zp_addr == `IFE_ADDR_PORT_A))
      begin
        port_a_data <= zp_wdata;
        port_a_oe   <= ~zp_wdata;
      end
      if (zp_wr && (zp_addr == `IFE_ADDR_PORT_B))
      begin
        port_b_data <= zp_wdata;
        port_b_oe   <= ~zp_wdata;
      end
    end
  end

  // Vector sequencer; reset outranks unmaskable, which outranks maskable
  always @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state      <= ST_IDLE;
      reset_pend <= 1'b1;
      nmi_pend   <= 1'b0;
      vec_valid  <= 1'b0;
      vec_kind   <= `IFE_KIND_RESET;
      vec_addr   <= `IFE_VEC_RESET;
    end
    else
    begin
      // An edge landing on the acknowledge cycle stays pending
      if (nmi_fall[0])
        nmi_pend <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (reset_pend)
          begin
            vec_valid <= 1'b1;
            vec_kind  <= `IFE_KIND_RESET;
            vec_addr  <= `IFE_VEC_RESET;
            state     <= ST_VEC;
          end
          else if (nmi_pend)
          begin
            vec_valid <= 1'b1;
            vec_kind  <= `IFE_KIND_NMI;
            vec_addr  <= `IFE_VEC_NMI;
            state     <= ST_VEC;
          end
          else if (irq_req && !cpu_irq_mask)
          begin
            vec_valid <= 1'b1;
            vec_kind  <= `IFE_KIND_IRQ;
            vec_addr  <= `IFE_VEC_IRQ;
            state     <= ST_VEC;
          end
        end
        ST_VEC:
        begin
          if (vec_ack)
          begin
            vec_valid <= 1'b0;
            state     <= ST_IDLE;
            if (vec_kind == `IFE_KIND_RESET)
              reset_pend <= 1'b0;
            if ((vec_kind == `IFE_KIND_NMI) && !nmi_fall[0])
              nmi_pend <= 1'b0;
          end
        end
        default:
        begin
          state     <= ST_IDLE;
          vec_valid <= 1'b0;
        end
      endcase
    end
  end

  // Bit instruction decode: opcode bits 6:4 pick the bit
  assign bop_bit     = bop_opcode[6:4];
  assign bop_mask    = 8'h01 << bop_bit;
  assign bop_low     = bop_opcode[3:0];
  assign bop_bit_val = |(bop_operand & bop_mask);

  always @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      bop_done      <= 1'b0;
      bop_result    <= 8'h00;
      bop_is_branch <= 1'b0;
      bop_taken     <= 1'b0;
      bop_bad       <= 1'b0;
    end
    else
    begin
      bop_done <= bop_valid;
      if (bop_valid)
      begin
        bop_result    <= bop_operand;
        bop_is_branch <= 1'b0;
        bop_taken     <= 1'b0;
        bop_bad       <= 1'b0;
        case (bop_low)
          `IFE_OP_BITWR_LO:
          begin
            if (bop_opcode[7])
              bop_result <= bop_operand | bop_mask;
            else
              bop_result <= bop_operand & ~bop_mask;
          end
          `IFE_OP_BRANCH_LO:
          begin
            bop_is_branch <= 1'b1;
            // Opcode bit 7 picks taken-if-one versus taken-if-zero
            if (bop_opcode[7])
              bop_taken <= bop_bit_val;
            else
              bop_taken <= ~bop_bit_val;
          end
          default:
            bop_bad <= 1'b1;
        endcase
      end
    end
  end

endmodule

/* hdl/ife_consts.vh */
// Purpose: constants for the maskable interrupt flag/enable block
// Assumes: page-zero register addresses are 8 bits wide
// Notes:   every offset lives here, with flag/enable/port reset values and flag 4-7 bit positions
//
// How it works
// - Maskable request comes from eight sources: counters, edges, serial.
// - Vectors: unmaskable 3FF7, chip reset 3FFA, maskable 3FFD.
// - Sequence reset, unmaskable, maskable; all eight share one request.
// - Each source has its own enable bit.
// - Request stays high while any enabled flag stays set.
// - Reading 0011 returns flags with no side effect on edge flags.
// - 0010 reads FF; clear-bit write there lands in the flag register.
// - A written one never sets an edge flag.
// - A flag set after the read cycle survives the write cycle.
// - Enable register at 0012; written ones set, zeros clear.
// - Chip reset clears every enable bit.
// - Flag set with its enable one raises the maskable request.
// - Read cycle of bit set/clear reads port data register, not pins.
// - Bit-set: byte one gives bit, byte two zero-page address.
// - Bit-clear is bit-set writing zero instead.
// - Branch-if-one: bit field, address, 8-bit offset; taken if one.
// - Branch-if-zero: same format, taken when the bit is zero.
// - Flags 0,1 on rising port A 0,1; flags 2,3 falling on 2,3.
// - Edge flags clear only by clear-bit at 0010 or chip reset.
// - Underflow sets flags 4,5; 0018/001C reads, 001A/001E writes clear.
// - Flag 6 from receiver status 0-3, flag 7 from transmitter status.
`ifndef IFE_CONSTS_VH
`define IFE_CONSTS_VH

`define IFE_ADDR_PORT_A   8'h00
`define IFE_ADDR_PORT_B   8'h01
`define IFE_ADDR_FLAG_CLR 8'h10
`define IFE_ADDR_FLAGS    8'h11
`define IFE_ADDR_ENABLES  8'h12
`define IFE_ADDR_CTRA_LO  8'h18
`define IFE_ADDR_CTRA_WR  8'h1A
`define IFE_ADDR_CTRB_LO  8'h1C
`define IFE_ADDR_CTRB_WR  8'h1E

`define IFE_CLR_READ_VAL  8'hFF
`define IFE_FLAGS_RESET   8'h00
`define IFE_ENABLES_RESET 8'h00
`define IFE_PORT_RESET    8'hFF

`define IFE_FLAG_CTRA     4
`define IFE_FLAG_CTRB     5
`define IFE_FLAG_RX       6
`define IFE_FLAG_TX       7
`define IFE_SS_TX_IDLE    5
`define IFE_SS_TX_EMPTY   6
`define IFE_SS_TX_END     7

`define IFE_VEC_NMI       16'h3FF7
`define IFE_VEC_RESET     16'h3FFA
`define IFE_VEC_IRQ       16'h3FFD
`define IFE_KIND_RESET    2'h0
`define IFE_KIND_NMI      2'h1
`define IFE_KIND_IRQ      2'h2

`define IFE_OP_BITWR_LO   4'h7
`define IFE_OP_BRANCH_LO  4'hF

`endif

/* hdl/ife_sync_edge.v */
// Purpose: two-stage synchroniser with edge detection for pin inputs
// Assumes: rst_n is already synchronous-release
// Notes:   edges are suppressed until the sample pipeline has filled
`timescale 1ns/1ps
module ife_sync_edge #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Pins and results
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level,
  output reg  [WIDTH-1:0] rise,
  output reg  [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] prev;
  reg [1:0]       fill;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= {WIDTH{1'b0}};
      level  <= {WIDTH{1'b0}};
      prev   <= {WIDTH{1'b0}};
      rise   <= {WIDTH{1'b0}};
      fall   <= {WIDTH{1'b0}};
      fill   <= 2'h0;
    end
    else
    begin
      stage1 <= pin_in;
      level  <= stage1;
      prev   <= level;
      if (fill != 2'h3)
        fill <= fill + 2'h1;
      // Pin state at reset release must not look like an edge
      rise <= (fill == 2'h3) ? (level & ~prev) : {WIDTH{1'b0}};
      fall <= (fill == 2'h3) ? (~level & prev) : {WIDTH{1'b0}};
    end
  end

endmodule

/* testbench/ife_irq_asserts.sv */
// Purpose: port-level checks for the interrupt flag/enable block
// Assumes: bound to ife_irq_ctrl; rst_n low disables every check
// Notes:   register reads answer one edge after the strobe edge
`timescale 1ns/1ps
module ife_irq_asserts (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Page-zero bus
  input wire [7:0]  zp_addr,
  input wire        zp_rd,
  input wire        zp_wr,
  input wire [7:0]  zp_wdata,
  input wire [7:0]  zp_rdata,
  input wire        zp_hit,
  // Bit helper
  input wire        bop_valid,
  input wire [7:0]  bop_opcode,
  input wire [7:0]  bop_operand,
  input wire        bop_done,
  input wire [7:0]  bop_result,
  input wire        bop_taken,
  // Vectors and request
  input wire        vec_valid,
  input wire        vec_ack,
  input wire [1:0]  vec_kind,
  input wire [15:0] vec_addr,
  input wire        irq_req,
  // Sources
  input wire        ctr_a_underflow,
  input wire [7:0]  serial_status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_clr_reads_ones: assert property (
    zp_rd && zp_addr == 8'h10 |=> zp_hit && zp_rdata == 8'hFF)
    else $error("flag clear address did not read FF");
  a_enable_read_back: assert property (
    zp_wr && zp_addr == 8'h12 ##1 !zp_wr ##1 zp_rd && zp_addr == 8'h12
    |=> zp_rdata == $past(zp_wdata, 3))
    else $error("enable register lost written value");
  a_uflow_sets_flag: assert property (
    ctr_a_underflow ##2 zp_rd && zp_addr == 8'h11 |=> zp_rdata[4])
    else $error("counter A underflow flag not set");
  a_irq_drop_cause: assert property (
    $fell(irq_req) |-> $past(zp_wr) || $past(zp_rd)
    || $past(serial_status) != $past(serial_status, 2))
    else $error("request dropped with no clearing access");
  a_vector_map: assert property (
    vec_valid |-> (vec_kind == 2'h0 && vec_addr == 16'h3FFA)
    || (vec_kind == 2'h1 && vec_addr == 16'h3FF7)
    || (vec_kind == 2'h2 && vec_addr == 16'h3FFD))
    else $error("vector address does not match kind");
  a_vector_stands: assert property (
    vec_valid && !vec_ack |=> vec_valid && $stable(vec_addr))
    else $error("vector withdrawn before acknowledge");
  a_bit_write_op: assert property (
    bop_valid && bop_opcode[3:0] == 4'h7 |=> bop_done
    && bop_result[$past(bop_opcode[6:4])] == $past(bop_opcode[7]))
    else $error("bit write gave wrong bit value");
  a_branch_test_op: assert property (
    bop_valid && bop_opcode[3:0] == 4'hF |=> bop_taken ==
    ($past(bop_operand[bop_opcode[6:4]]) == $past(bop_opcode[7])))
    else $error("branch decision wrong");

  c_vec_taken: cover property (vec_valid && vec_ack);
  c_irq_fell:  cover property ($fell(irq_req));
  c_clr_read:  cover property (zp_rd && zp_addr == 8'h10);
endmodule

bind ife_irq_ctrl ife_irq_asserts ife_irq_asserts_inst (.clk, .rst_n,
  .zp_addr, .zp_rd, .zp_wr, .zp_wdata, .zp_rdata, .zp_hit, .bop_valid,
  .bop_opcode, .bop_operand, .bop_done, .bop_result, .bop_taken,
  .vec_valid, .vec_ack, .vec_kind, .vec_addr, .irq_req,
  .ctr_a_underflow, .serial_status);

/* testbench/ife_cpu_model.sv */
// Purpose: CPU core stand-in for page-zero, bit-op and vector ports
// Assumes: each request launches after an edge and is taken at the next
// Notes:   released write data shows its inverse, never a stale copy
`timescale 1ns/1ps
module ife_cpu_model (
  // Clock
  input  wire       clk,
  // Page-zero bus
  output reg  [7:0] zp_addr,
  output reg        zp_rd,
  output reg        zp_wr,
  output reg        zp_rmw,
  output reg  [7:0] zp_wdata,
  input  wire [7:0] zp_rdata,
  // Bit helper
  output reg        bop_valid,
  output reg  [7:0] bop_opcode,
  output reg  [7:0] bop_operand,
  // Vectors
  output reg        cpu_irq_mask,
  output reg        vec_ack,
  input  wire       vec_valid
);
  initial
  begin
    {zp_addr, zp_rd, zp_wr, zp_rmw, zp_wdata} = 19'h0;
    {bop_valid, bop_opcode, bop_operand, vec_ack} = 18'h0;
    cpu_irq_mask = 1'b1;
  end

  task rd(input [7:0] a, input m, output [7:0] d);
  begin
    @(posedge clk);
    zp_addr <= a;
    zp_rmw  <= m;
    zp_rd   <= 1'b1;
    @(posedge clk);
    zp_rd  <= 1'b0;
    zp_rmw <= 1'b0;
    #1;
    d = zp_rdata;
  end
  endtask

  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    zp_addr  <= a;
    zp_wdata <= d;
    zp_wr    <= 1'b1;
    @(posedge clk);
    zp_wr    <= 1'b0;
    zp_wdata <= ~d;
  end
  endtask

  task bop(input [7:0] op, input [7:0] opnd);
  begin
    @(posedge clk);
    bop_opcode  <= op;
    bop_operand <= opnd;
    bop_valid   <= 1'b1;
    @(posedge clk);
    bop_valid <= 1'b0;
    #1;
  end
  endtask

  // Slow acknowledge is allowed: the vector must stand meanwhile
  task take_vec(input integer dly, output [1:0] k, output [15:0] a);
  integer i;
  begin
    a = 16'h0000;
    for (i = 0; i < 40 && a == 16'h0000; i = i + 1)
    begin
      @(posedge clk);
      #1;
      k = ife_irq_ctrl_bench.vec_kind;
      a = vec_valid ? ife_irq_ctrl_bench.vec_addr : 16'h0000;
    end
    repeat (dly + 1) @(posedge clk);
    vec_ack      <= 1'b1;
    cpu_irq_mask <= 1'b1;
    @(posedge clk);
    vec_ack <= 1'b0;
  end
  endtask
endmodule

/* testbench/ife_irq_ctrl_bench.sv */
// Purpose: self-checking bench for the interrupt flag/enable block
// Assumes: 20 MHz clock; port pins are open drain with pull-ups
// Notes:   scenarios run in order and rely on the flags left behind
`timescale 1ns/1ps
module ife_irq_ctrl_bench;
  logic        clk, rst_n, nmi_n_pin, ctr_a_underflow, ctr_b_underflow;
  logic [7:0]  serial_status, pa_drv, pb_drv, d;
  logic [1:0]  k;
  logic [15:0] a;
  logic [2:0]  b;
  integer      num_errors, n_tests, i;
  wire  [7:0]  zp_addr, zp_wdata, zp_rdata, bop_opcode, bop_operand;
  wire  [7:0]  bop_result, port_a_out, port_a_oe, port_b_out, port_b_oe;
  wire         zp_rd, zp_wr, zp_rmw, zp_hit, bop_valid, bop_done, vec_ack;
  wire         bop_is_branch, bop_taken, bop_bad, cpu_irq_mask, vec_valid;
  wire         irq_req;
  wire  [1:0]  vec_kind;
  wire  [15:0] vec_addr;
  wire  [7:0]  port_a_in = pa_drv & ~port_a_oe;
  wire  [7:0]  port_b_in = pb_drv & ~port_b_oe;

  ife_irq_ctrl ife_irq_ctrl_inst (.clk, .rst_n, .zp_addr, .zp_rd, .zp_wr,
    .zp_rmw, .zp_wdata, .zp_rdata, .zp_hit, .bop_valid, .bop_opcode,
    .bop_operand, .bop_done, .bop_result, .bop_is_branch, .bop_taken,
    .bop_bad, .nmi_n_pin, .cpu_irq_mask, .vec_ack, .vec_valid, .vec_kind,
    .vec_addr, .irq_req, .ctr_a_underflow, .ctr_b_underflow,
    .serial_status, .port_a_in, .port_a_out, .port_a_oe, .port_b_in,
    .port_b_out, .port_b_oe);
  ife_cpu_model ife_cpu_model_inst (.clk, .zp_addr, .zp_rd, .zp_wr,
    .zp_rmw, .zp_wdata, .zp_rdata, .bop_valid, .bop_opcode, .bop_operand,
    .cpu_irq_mask, .vec_ack, .vec_valid);

  always #25 clk = ~clk;

  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  end
  endtask

  task fl(input [7:0] e);
  begin
    ife_cpu_model_inst.rd(8'h11, 1'b0, d);
    chk("flags", {8'h00, e}, {8'h00, d});
  end
  endtask

  task pins(input [7:0] v);
  begin
    @(posedge clk);
    pa_drv <= v;
    repeat (7) @(posedge clk);
  end
  endtask

  task t_reset;
  begin
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    ife_cpu_model_inst.take_vec(0, k, a);
    chk("rst_kind", 16'h0, {14'h0, k});
    chk("rst_vec", 16'h3FFA, a);
    fl(8'h00);
    ife_cpu_model_inst.rd(8'h12, 1'b0, d);
    chk("enables", 16'h0, {8'h00, d});
  end
  endtask

  task t_edges;
  begin
    ife_cpu_model_inst.wr(8'h12, 8'hFF);
    pins(8'h03);
    fl(8'h0F);
    chk("irq", 16'h1, {15'h0, irq_req});
    ife_cpu_model_inst.wr(8'h10, 8'hFF);
    ife_cpu_model_inst.wr(8'h11, 8'h00);
    fl(8'h0F);
    for (i = 0; i < 4; i = i + 1)
    begin
      chk("irq_held", 16'h1, {15'h0, irq_req});
      ife_cpu_model_inst.rd(8'h10, 1'b1, d);
      chk("clr_read", 16'hFF, {8'h00, d});
      ife_cpu_model_inst.wr(8'h10, d & ~(8'h01 << i));
      fl(8'h0F & (8'h0E << i));
    end
    chk("irq_off", 16'h0, {15'h0, irq_req});
  end
  endtask

  // Edge on line 1 lands between the read and write of a clear
  task t_race;
  begin
    pins(8'h00);
    pins(8'h01);
    ife_cpu_model_inst.rd(8'h10, 1'b1, d);
    pins(8'h03);
    ife_cpu_model_inst.wr(8'h10, 8'hFE);
    fl(8'h02);
  end
  endtask

  task t_enables;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      ife_cpu_model_inst.wr(8'h12, 8'h01 << i);
      ife_cpu_model_inst.rd(8'h12, 1'b0, d);
      chk("enable_rd", 16'h1 << i, {8'h00, d});
      chk("irq_mask", {15'h0, i == 1}, {15'h0, irq_req});
    end
    ife_cpu_model_inst.wr(8'h12, 8'hFF);
  end
  endtask

  task t_counters;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk);
      ctr_a_underflow <= (i < 2);
      ctr_b_underflow <= (i >= 2);
      @(posedge clk);
      ctr_a_underflow <= 1'b0;
      ctr_b_underflow <= 1'b0;
      fl((i < 2) ? 8'h12 : 8'h22);
      if (i[0])
        ife_cpu_model_inst.wr({4'h1, 1'b1, i[1], 2'b10}, 8'h00);
      else
        ife_cpu_model_inst.rd({4'h1, 1'b1, i[1], 2'b00}, 1'b0, d);
      fl(8'h02);
    end
  end
  endtask

  task t_serial;
  logic [7:0] sv [6];
  logic [7:0] se [6];
  begin
    sv = '{8'h01, 8'h08, 8'h40, 8'h60, 8'h80, 8'h00};
    se = '{8'h42, 8'h42, 8'h82, 8'h02, 8'h82, 8'h02};
    for (i = 0; i < 6; i = i + 1)
    begin
      @(posedge clk);
      serial_status <= sv[i];
      repeat (3) @(posedge clk);
      fl(se[i]);
    end
  end
  endtask

  task t_ports;
  begin
    ife_cpu_model_inst.wr(8'h01, 8'h5A);
    @(posedge clk);
    pb_drv <= 8'h0F;
    repeat (4) @(posedge clk);
    chk("pb_oe", 16'hA5, {8'h00, port_b_oe});
    chk("pb_out", 16'h0, {8'h00, port_b_out});
    ife_cpu_model_inst.rd(8'h01, 1'b0, d);
    chk("pb_pins", 16'h0A, {8'h00, d});
    ife_cpu_model_inst.rd(8'h01, 1'b1, d);
    chk("pb_rmw", 16'h5A, {8'h00, d});
    ife_cpu_model_inst.rd(8'h00, 1'b1, d);
    chk("pa_rmw", 16'hFF, {8'h00, d});
    chk("pa_drive", 16'h0, {port_a_oe, port_a_out});
  end
  endtask

  task t_bitops;
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      b = i[2:0];
      ife_cpu_model_inst.bop({1'b1, b, 4'h7}, 8'h00);
      chk("set", {8'h00, 8'h01 << b}, {8'h00, bop_result});
      ife_cpu_model_inst.bop({1'b0, b, 4'h7}, 8'hFF);
      d = ~(8'h01 << b);
      chk("clr", {8'h00, d}, {8'h00, bop_result});
      ife_cpu_model_inst.bop({1'b1, b, 4'hF}, 8'h01 << b);
      chk("br_one", 16'h1, {15'h0, bop_taken});
      ife_cpu_model_inst.bop({1'b0, b, 4'hF}, 8'h01 << b);
      chk("br_zero", 16'h0, {15'h0, bop_taken});
    end
    chk("is_br", 16'h1, {15'h0, bop_is_branch});
    ife_cpu_model_inst.bop(8'h00, 8'h00);
    chk("bad_op", 16'h1, {15'h0, bop_bad});
  end
  endtask

  // Request is pending but masked, so the unmaskable vector goes first
  task t_vectors;
  begin
    @(posedge clk);
    nmi_n_pin <= 1'b0;
    ife_cpu_model_inst.take_vec(3, k, a);
    chk("nmi_kind", 16'h1, {14'h0, k});
    chk("nmi_vec", 16'h3FF7, a);
    @(posedge clk);
    nmi_n_pin <= 1'b1;
    ife_cpu_model_inst.cpu_irq_mask <= 1'b0;
    ife_cpu_model_inst.take_vec(0, k, a);
    chk("irq_kind", 16'h2, {14'h0, k});
    chk("irq_vec", 16'h3FFD, a);
  end
  endtask

  task end_sim;
  begin
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  initial
  begin
    #(50 * 20000);
    num_errors = num_errors + 1;
    end_sim;
  end

  initial
  begin
    {clk, rst_n, ctr_a_underflow, ctr_b_underflow} = 4'h0;
    nmi_n_pin = 1'b1;
    serial_status = 8'h00;
    pa_drv = 8'h0C;
    pb_drv = 8'hFF;
    num_errors = 0;
    n_tests = 0;
    t_reset;
    t_edges;
    t_race;
    t_enables;
    t_counters;
    t_serial;
    t_ports;
    t_bitops;
    t_vectors;
    t_reset;
    end_sim;
  end
endmodule
